// ---- verif/cmd_source.sv ----
`timescale 1ns/1ps
// ************************************************************
// Digital input lines as the field wiring presents them.
// ************************************************************
module cmd_source (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Requested line levels
	input  wire logic [6:0] lines_i,
	// Lines to the drive
	output logic      [1:0] sel_o,
	output logic            use_preset_o,
	output logic            catch_o,
	output logic            slow_o,
	output logic            jog_o,
	output logic            qstop_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{qstop_o, jog_o, slow_o, catch_o, use_preset_o, sel_o} <= 7'h00;
		end else begin
			{qstop_o, jog_o, slow_o, catch_o, use_preset_o, sel_o} <= lines_i;
		end
	end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	localparam longint FLR = 10000;
	localparam longint CEIL = 50000;
	logic clk_i = 0, rst_i = 1, we_i = 0, re_i = 0, lsel = 0, jser = 0, jpan = 0, qser = 0;
	logic start = 0, stop = 0, ce_i = 1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0, rdata_o;
	logic signed [31:0] an = 0, pu = 0, se = 0, lo = 0, hl = 7000, fq = 0, res_o, jf_o;
	logic [15:0] cur = 16'h0000, ceil_o;
	logic [6:0] lines = 7'h00;
	logic [1:0] sel, ssel = 2'h0;
	logic up, cu, sd, jdi, qdi, ja_o, qs_o, cl_o, lw_o, wd_o, wr_o;
	logic [18:0] qt_o;
	integer seed = 92, fail_count = 0, check_count = 0, cyc = 0, i, j, m;
	longint pv [4], x, k, e;
	logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C, 8'h20, 8'hFC};
	logic [31:0] rv [7] = '{32'h12C, 32'h2710, 32'h0, 32'h0, 32'h0, 32'h640, 32'h0};
	initial forever #20 clk_i = ~clk_i;
	cmd_source part_u (.clk_i(clk_i), .rst_i(rst_i), .lines_i(lines), .sel_o(sel),
		.use_preset_o(up), .catch_o(cu), .slow_o(sd), .jog_o(jdi), .qstop_o(qdi));
	drive_reference_combiner dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .analog_ref_i(an),
		.pulse_ref_i(pu), .serial_ref_i(se), .local_ref_i(lo), .local_ref_sel_i(lsel),
		.preset_sel_di_i(sel), .preset_sel_ser_i(ssel), .use_preset_i(up), .catch_up_i(cu),
		.slow_down_i(sd), .jog_di_i(jdi), .jog_ser_i(jser), .jog_panel_i(jpan),
		.qstop_di_i(qdi), .qstop_ser_i(qser), .output_freq_high_limit_i(hl),
		.start_cmd_i(start), .stop_cmd_i(stop), .output_freq_i(fq), .output_current_i(cur),
		.resulting_ref_o(res_o), .jog_active_o(ja_o), .jog_output_freq_o(jf_o),
		.quick_stop_o(qs_o), .qstop_time_o(qt_o), .output_current_ceiling_o(ceil_o),
		.current_limit_o(cl_o), .low_current_warn_o(lw_o), .warn_dout_o(wd_o),
		.warn_relay_o(wr_o));
	function automatic longint model(longint x, int m, longint p, bit u, bit c, bit s, longint k);
		longint r;
		r = (m == 0) ? x + (CEIL - FLR) * p / 10000 : (m == 1) ? x + x * p / 10000
			: (u ? (CEIL - FLR) * p / 10000 : x);
		k = r * k / 10000;
		if (c && !s) r = r + k;
		if (s && !c) r = r - k;
		r = r + FLR;
		return (r < FLR) ? FLR : (r > CEIL) ? CEIL : r;
	endfunction
	task automatic chk(input string n, input logic signed [63:0] s, input logic signed [63:0] x);
		check_count++;
		if (s !== x) begin
			fail_count++;
			$display("wrong value %s expected %0d seen %0d", n, x, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input longint d);
		@(posedge clk_i);
		we_i <= 1'b1; addr_i <= a; wdata_i <= 32'(d);
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk_i);
		re_i <= 1'b1; addr_i <= a;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1 chk("rdata", rdata_o, x);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict;
		end
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 7; i++) rd(ra[i], rv[i]);
		chk("qtime", qt_o, 300);
		wr(8'h00, 1); settle(2); chk("qtime", qt_o, 2);
		wr(8'h00, 400000); settle(2); chk("qtime", qt_o, 360000);
		$display("test reset values done");
		wr(8'h28, FLR); wr(8'h2C, CEIL); wr(8'h0C, 1500);
		an <= 16000; lines <= 7'h04;
		for (m = 0; m < 3; m++) begin
			wr(8'h08, m); settle(4);
			chk("result", res_o, model(16000, m, 1500, 1, 0, 0, 0));
		end
		wr(8'h08, 3); rd(8'h08, 32'h2);
		$display("test worked examples done");
		for (i = 0; i < 60; i++) begin
			for (j = 0; j < 4; j++) begin
				pv[j] = $random(seed) % 10001;
				wr(8'h0C + 8'(4 * j), pv[j]);
			end
			k = {$random(seed)} % 10001; m = {$random(seed)} % 3;
			j = {$random(seed)} % 2;
			wr(8'h30, 8 * j);
			wr(8'h1C, k); wr(8'h08, m);
			an <= $random(seed) % 20000; pu <= $random(seed) % 20000; se <= $random(seed) % 20000;
			lo <= $random(seed); lsel <= ($random(seed) % 4 == 0); ssel <= $random(seed);
			lines <= 7'($random(seed)) & 7'h1F;
			settle(4);
			x = longint'(an) + pu + se;
			e = lsel ? longint'(lo) : model(x, m, pv[j ? ssel : lines[1:0]], up, cu, sd, k);
			chk("result", res_o, e);
			rd(8'h38, 32'(e));
		end
		$display("test random references done");
		lsel <= 0; lines <= 7'h00; qser <= 1; settle(2); chk("qstop", qs_o, 1);
		qser <= 0; lines <= 7'h40; settle(3); chk("qstop", qs_o, 1);
		lines <= 7'h00; jpan <= 1; settle(2); chk("jog", ja_o, 0);
		wr(8'h30, 1); settle(2); chk("jog", ja_o, 1);
		chk("jogfreq", jf_o, 7000);
		jpan <= 0; lines <= 7'h20; settle(3); chk("jog", ja_o, 1);
		lines <= 7'h00; jser <= 1; settle(3); chk("jog", ja_o, 1);
		$display("test jog and quick stop done");
		lines <= 7'h00; jser <= 0; wr(8'h30, 6); wr(8'h24, 500); wr(8'h08, 0); wr(8'h1C, 0);
		for (j = 0; j < 4; j++) wr(8'h0C + 8'(4 * j), 0);
		an <= 5000; pu <= 0; se <= 0; cur <= 16'h0064;
		settle(4); chk("warn", lw_o, 0);
		start <= 1; settle(1); start <= 0; settle(5); chk("warn", lw_o, 0);
		fq <= 32'(model(5000, 0, 0, 0, 0, 0, 0)); settle(3);
		chk("warn", lw_o, 1); chk("dout", wd_o, 1); chk("relay", wr_o, 1);
		rd(8'h34, 32'h11);
		stop <= 1; settle(1); stop <= 0; settle(2); chk("warn", lw_o, 0);
		cur <= 16'h0640; settle(2); chk("limit", cl_o, 1); chk("ceil", ceil_o, 1600);
		$display("test warnings done");
		ce_i <= 1'b0; an <= 9000; settle(4);
		chk("freeze", res_o, model(5000, 0, 0, 0, 0, 0, 0));
		ce_i <= 1'b1; settle(4);
		chk("result", res_o, model(9000, 0, 0, 0, 0, 0, 0));
		$display("test clock enable done");
		give_verdict;
	end
endmodule

// ---- verilog/drive_reference_combiner.sv ----
`timescale 1ns/1ps
// Contract
// - Quick-stop time register, 0.02 to 3600.00 s, default 3.00 s.
// - Quick stop starts from its digital input or the serial link.
// - Jog drives a fixed jog frequency, 0 to high limit, default 10 Hz.
// - Jog from inputs or serial always; from panel only when permitted.
// - Combining mode: additive 0, proportional 1, switchover 2; additive default.
// - Additive adds preset percent of reference span to external reference.
// - Proportional adds preset percent of the external reference sum.
// - Switchover input picks external or span-scaled preset reference.
// - External reference is analog plus pulse plus serial references.
// - Additive or proportional always applies one preset; zero leaves unchanged.
// - Four signed presets, -100.00 to +100.00 percent, reset to zero.
// - Two select bits, upper then lower, choose presets one to four.
// - Catch-up input adds offset percent, 0 to 100, default zero.
// - Slow-down input subtracts the same offset percent.
// - Remote reference is preset plus external, or one of the two in switchover; offsets act on it.
// - Output current ceiling in percent of rated, default 160 percent.
// - Low-current warning while measured current is under the threshold.
// - Warnings off during start ramp, after stop, while stopped; on at reference.
// - Active warning routes by configuration to digital and relay outputs.
// - Total reference clamped to floor and ceiling except on local reference.
module drive_reference_combiner #(
	parameter int REF_W = 32,
	parameter int CUR_W = 16
) (
	// Clock, reset and enable
	input  wire logic                                  clk_i,
	input  wire logic                                  rst_i,
	input  wire logic                                  ce_i,
	// Register port
	input  wire logic [ref_combiner_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [31:0]                           wdata_i,
	input  wire logic                                  we_i,
	input  wire logic                                  re_i,
	output logic      [31:0]                           rdata_o,
	// Reference sources
	input  wire logic signed [REF_W-1:0]               analog_ref_i,
	input  wire logic signed [REF_W-1:0]               pulse_ref_i,
	input  wire logic signed [REF_W-1:0]               serial_ref_i,
	input  wire logic signed [REF_W-1:0]               local_ref_i,
	input  wire logic                                  local_ref_sel_i,
	// Preset and offset commands
	input  wire logic [1:0]                            preset_sel_di_i,
	input  wire logic [1:0]                            preset_sel_ser_i,
	input  wire logic                                  use_preset_i,
	input  wire logic                                  catch_up_i,
	input  wire logic                                  slow_down_i,
	// Jog and quick stop commands
	input  wire logic                                  jog_di_i,
	input  wire logic                                  jog_ser_i,
	input  wire logic                                  jog_panel_i,
	input  wire logic                                  qstop_di_i,
	input  wire logic                                  qstop_ser_i,
	input  wire logic signed [REF_W-1:0]               output_freq_high_limit_i,
	// Run state and measurements
	input  wire logic                                  start_cmd_i,
	input  wire logic                                  stop_cmd_i,
	input  wire logic signed [REF_W-1:0]               output_freq_i,
	input  wire logic [CUR_W-1:0]                      output_current_i,
	// Results
	output logic signed [REF_W-1:0]                    resulting_ref_o,
	output logic                                       jog_active_o,
	output logic signed [REF_W-1:0]                    jog_output_freq_o,
	output logic                                       quick_stop_o,
	output logic [ref_combiner_pkg::QSTOP_W-1:0]       qstop_time_o,
	output logic [CUR_W-1:0]                           output_current_ceiling_o,
	output logic                                       current_limit_o,
	output logic                                       low_current_warn_o,
	output logic                                       warn_dout_o,
	output logic                                       warn_relay_o
);
	localparam int RW = REF_W + 2;
	localparam int AW = ref_combiner_pkg::ADDR_W;
	localparam int PW = ref_combiner_pkg::PCT_W;
	localparam int PCT_MAX = ref_combiner_pkg::PCT_FULL;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic signed [RW-1:0] clamp_s(input logic signed [RW-1:0] v,
		input logic signed [RW-1:0] lo, input logic signed [RW-1:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	function automatic logic preset_hit(input logic [AW-1:0] a);
		return (a >= ref_combiner_pkg::OFS_PRESET0) && (a < ref_combiner_pkg::OFS_CATCH)
			&& (a[1:0] == 2'h0);
	endfunction

	function automatic logic [1:0] preset_idx(input logic [AW-1:0] a);
		logic [AW-1:0] d;
		d = a - ref_combiner_pkg::OFS_PRESET0;
		return d[3:2];
	endfunction

	// ************************************************************
	// Configuration registers
	// ************************************************************
	logic        [ref_combiner_pkg::QSTOP_W-1:0] qstop_q;
	logic signed [REF_W-1:0]                     jog_q;
	logic        [1:0]                           mode_q;
	logic signed [PW-1:0]                        preset_q [ref_combiner_pkg::PRESET_NUM];
	logic signed [PW-1:0]                        catch_q;
	logic        [CUR_W-1:0]                     output_current_ceiling_q;
	logic        [CUR_W-1:0]                     low_current_threshold_q;
	logic signed [REF_W-1:0]                     floor_q;
	logic signed [REF_W-1:0]                     ceil_q;
	logic        [ref_combiner_pkg::CTRL_W-1:0]  ctrl_q;
	logic signed [RW-1:0]                        wsx;

	assign wsx = RW'($signed(wdata_i));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			qstop_q <= ref_combiner_pkg::QSTOP_W'(ref_combiner_pkg::QSTOP_RST_CS);
			jog_q   <= REF_W'(ref_combiner_pkg::JOG_RST_MHZ);
			mode_q  <= ref_combiner_pkg::MODE_ADD;
			for (int i = 0; i < ref_combiner_pkg::PRESET_NUM; i++) begin
				preset_q[i] <= PW'(ref_combiner_pkg::PRESET_RST);
			end
			catch_q <= PW'(ref_combiner_pkg::CATCH_RST);
			output_current_ceiling_q  <= CUR_W'(ref_combiner_pkg::OUTPUT_CURRENT_CEILING_RST);
			low_current_threshold_q  <= CUR_W'(ref_combiner_pkg::LOW_CURRENT_THRESHOLD_RST);
			floor_q <= REF_W'(ref_combiner_pkg::FLOOR_RST);
			ceil_q  <= REF_W'(ref_combiner_pkg::CEIL_RST);
			ctrl_q  <= ref_combiner_pkg::CTRL_RST;
		end else if (ce_i && we_i) begin
			if (addr_i == ref_combiner_pkg::OFS_QSTOP) begin
				qstop_q <= ref_combiner_pkg::QSTOP_W'(clamp_s(wsx,
					RW'(ref_combiner_pkg::QSTOP_MIN_CS), RW'(ref_combiner_pkg::QSTOP_MAX_CS)));
			end else if (addr_i == ref_combiner_pkg::OFS_JOG) begin
				jog_q <= (wsx < 0) ? '0 : REF_W'(wsx);
			end else if (addr_i == ref_combiner_pkg::OFS_MODE) begin
				if (wdata_i[1:0] != 2'h3) begin
					mode_q <= wdata_i[1:0];
				end
			end else if (addr_i == ref_combiner_pkg::OFS_CATCH) begin
				catch_q <= PW'(clamp_s(wsx, RW'(0), RW'(PCT_MAX)));
			end else if (addr_i == ref_combiner_pkg::OFS_OUTPUT_CURRENT_CEILING) begin
				output_current_ceiling_q <= wdata_i[CUR_W-1:0];
			end else if (addr_i == ref_combiner_pkg::OFS_LOW_CURRENT_THRESHOLD) begin
				low_current_threshold_q <= wdata_i[CUR_W-1:0];
			end else if (addr_i == ref_combiner_pkg::OFS_FLOOR) begin
				floor_q <= REF_W'(wsx);
			end else if (addr_i == ref_combiner_pkg::OFS_CEIL) begin
				ceil_q <= REF_W'(wsx);
			end else if (addr_i == ref_combiner_pkg::OFS_CTRL) begin
				ctrl_q <= wdata_i[ref_combiner_pkg::CTRL_W-1:0];
			end else if (preset_hit(addr_i)) begin
				preset_q[preset_idx(addr_i)] <= PW'(clamp_s(wsx, RW'(-PCT_MAX), RW'(PCT_MAX)));
			end
		end
	end

	// ************************************************************
	// Command stage
	// ************************************************************
	logic signed [RW-1:0]    ext_q;
	logic signed [REF_W-1:0] local_q;
	logic                    local_sel_q;
	logic [1:0]              sel_q;
	logic                    use_preset_q;
	logic                    cu_q;
	logic                    sd_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_q        <= '0;
			local_q      <= '0;
			local_sel_q  <= 1'b0;
			sel_q        <= 2'h0;
			use_preset_q <= 1'b0;
			cu_q         <= 1'b0;
			sd_q         <= 1'b0;
		end else if (ce_i) begin
			ext_q        <= RW'(analog_ref_i) + RW'(pulse_ref_i) + RW'(serial_ref_i);
			local_q      <= local_ref_i;
			local_sel_q  <= local_ref_sel_i;
			sel_q        <= ctrl_q[ref_combiner_pkg::CTRL_PRESET_SER] ? preset_sel_ser_i
				: preset_sel_di_i;
			use_preset_q <= use_preset_i;
			cu_q         <= catch_up_i;
			sd_q         <= slow_down_i;
		end
	end

	// ************************************************************
	// Reference arithmetic
	// ************************************************************
	logic signed [RW-1:0] span;
	logic signed [PW-1:0] preset_pick;
	logic signed [RW-1:0] span_part;
	logic signed [RW-1:0] rel_part;
	logic signed [RW-1:0] remote;
	logic signed [RW-1:0] off_part;
	logic signed [RW-1:0] offs;
	logic signed [RW-1:0] total;
	logic signed [RW-1:0] result_d;

	assign span        = RW'(ceil_q) - RW'(floor_q);
	assign preset_pick = preset_q[sel_q];

	pct_scale #(.W(RW)) u_span (.base_i(span), .pct_i(preset_pick), .part_o(span_part));
	pct_scale #(.W(RW)) u_rel (.base_i(ext_q), .pct_i(preset_pick), .part_o(rel_part));
	pct_scale #(.W(RW)) u_off (.base_i(remote), .pct_i(catch_q), .part_o(off_part));

	always_comb begin
		case (mode_q)
			ref_combiner_pkg::MODE_REL: begin
				remote = ext_q + rel_part;
			end
			ref_combiner_pkg::MODE_SWITCH: begin
				remote = use_preset_q ? span_part : ext_q;
			end
			default: begin
				remote = ext_q + span_part;
			end
		endcase
	end

	always_comb begin
		if (cu_q && !sd_q) begin
			offs = off_part;
		end else if (sd_q && !cu_q) begin
			offs = -off_part;
		end else begin
			offs = '0;
		end
		total    = remote + offs + RW'(floor_q);
		result_d = local_sel_q ? RW'(local_q)
			: clamp_s(total, RW'(floor_q), RW'(ceil_q));
	end

	// Inputs reach the output one edge after the command stage samples them.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resulting_ref_o <= '0;
		end else if (ce_i) begin
			resulting_ref_o <= REF_W'(result_d);
		end
	end

	// ************************************************************
	// Jog, quick stop and current ceiling
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			jog_active_o             <= 1'b0;
			jog_output_freq_o        <= '0;
			quick_stop_o             <= 1'b0;
			qstop_time_o             <= '0;
			output_current_ceiling_o <= '0;
			current_limit_o          <= 1'b0;
		end else if (ce_i) begin
			jog_active_o <= jog_di_i || jog_ser_i
				|| (jog_panel_i && ctrl_q[ref_combiner_pkg::CTRL_PANEL_JOG]);
			jog_output_freq_o <= (jog_q > output_freq_high_limit_i)
				? output_freq_high_limit_i : jog_q;
			quick_stop_o             <= qstop_di_i || qstop_ser_i;
			qstop_time_o             <= qstop_q;
			output_current_ceiling_o <= output_current_ceiling_q;
			current_limit_o          <= output_current_i >= output_current_ceiling_q;
		end
	end

	// ************************************************************
	// Low-current warning
	// ************************************************************
	gate_if gif ();
	logic   low_d;

	assign gif.start  = start_cmd_i;
	assign gif.stop   = stop_cmd_i;
	assign gif.at_ref = (output_freq_i == resulting_ref_o);
	assign low_d      = gif.enable && (output_current_i < low_current_threshold_q);

	warn_gate u_gate (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .g(gif));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_current_warn_o <= 1'b0;
			warn_dout_o        <= 1'b0;
			warn_relay_o       <= 1'b0;
		end else if (ce_i) begin
			low_current_warn_o <= low_d;
			warn_dout_o        <= low_d && ctrl_q[ref_combiner_pkg::CTRL_ROUTE_DOUT];
			warn_relay_o       <= low_d && ctrl_q[ref_combiner_pkg::CTRL_ROUTE_RLY];
		end
	end

	// ************************************************************
	// Read port
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			rdata_o <= 32'h0000_0000;
			if (re_i) begin
				if (addr_i == ref_combiner_pkg::OFS_QSTOP) begin
					rdata_o <= 32'(qstop_q);
				end else if (addr_i == ref_combiner_pkg::OFS_JOG) begin
					rdata_o <= 32'(jog_q);
				end else if (addr_i == ref_combiner_pkg::OFS_MODE) begin
					rdata_o <= 32'(mode_q);
				end else if (addr_i == ref_combiner_pkg::OFS_CATCH) begin
					rdata_o <= 32'(catch_q);
				end else if (addr_i == ref_combiner_pkg::OFS_OUTPUT_CURRENT_CEILING) begin
					rdata_o <= 32'(output_current_ceiling_q);
				end else if (addr_i == ref_combiner_pkg::OFS_LOW_CURRENT_THRESHOLD) begin
					rdata_o <= 32'(low_current_threshold_q);
				end else if (addr_i == ref_combiner_pkg::OFS_FLOOR) begin
					rdata_o <= 32'(floor_q);
				end else if (addr_i == ref_combiner_pkg::OFS_CEIL) begin
					rdata_o <= 32'(ceil_q);
				end else if (addr_i == ref_combiner_pkg::OFS_CTRL) begin
					rdata_o <= 32'(ctrl_q);
				end else if (addr_i == ref_combiner_pkg::OFS_STATUS) begin
					rdata_o <= 32'({gif.enable, quick_stop_o, jog_active_o, current_limit_o,
						low_current_warn_o});
				end else if (addr_i == ref_combiner_pkg::OFS_RESULT) begin
					rdata_o <= 32'(resulting_ref_o);
				end else if (preset_hit(addr_i)) begin
					rdata_o <= 32'(preset_q[preset_idx(addr_i)]);
				end
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence stop_seen;
		ce_i && stop_cmd_i ##1 ce_i;
	endsequence

	sequence panel_only_jog;
		ce_i && jog_panel_i && !jog_di_i && !jog_ser_i;
	endsequence

	qstop_cmd_a: assert property ((ce_i && (qstop_di_i || qstop_ser_i)) |=> quick_stop_o)
		else $error("quick stop command not taken");
	jog_perm_a: assert property ((panel_only_jog and
		!ctrl_q[ref_combiner_pkg::CTRL_PANEL_JOG]) |=> !jog_active_o)
		else $error("panel jog taken without permission");
	jog_limit_a: assert property ($past(ce_i) |->
		jog_output_freq_o <= $past(output_freq_high_limit_i))
		else $error("jog frequency above high limit");
	mode_reset_a: assert property ($past(rst_i) |-> mode_q == ref_combiner_pkg::MODE_ADD
		&& qstop_q == ref_combiner_pkg::QSTOP_W'(ref_combiner_pkg::QSTOP_RST_CS))
		else $error("wrong reset mode or quick stop time");
	preset_range_a: assert property (preset_pick >= -PCT_MAX && preset_pick <= PCT_MAX)
		else $error("preset out of range");
	ref_clamp_a: assert property (($past(ce_i) && !$past(local_sel_q)
		&& $past(floor_q) <= $past(ceil_q)) |-> (resulting_ref_o >= $past(floor_q)
		&& resulting_ref_o <= $past(ceil_q)))
		else $error("resulting reference outside floor and ceiling");
	local_pass_a: assert property ((ce_i && local_ref_sel_i) ##1 ce_i |=>
		resulting_ref_o == $past(local_ref_i, 2))
		else $error("local reference not passed within update");
	offs_cancel_a: assert property ((cu_q && sd_q) |-> total == remote + RW'(floor_q))
		else $error("offset applied with both offset inputs");
	low_warn_a: assert property ((ce_i && gif.enable && output_current_i < low_current_threshold_q)
		|=> low_current_warn_o)
		else $error("low current warning missing");
	stop_quiet_a: assert property (stop_seen |=> !low_current_warn_o)
		else $error("warning active after stop");
	warn_route_a: assert property ((warn_dout_o || warn_relay_o) |-> low_current_warn_o)
		else $error("routed warning without active warning");
endmodule

// ---- verilog/gate_if.sv ----
`timescale 1ns/1ps
interface gate_if;
	logic start;
	logic stop;
	logic at_ref;
	logic enable;

	modport ctrl (output start, output stop, output at_ref, input enable);
	modport gate (input start, input stop, input at_ref, output enable);
endinterface

// ---- verilog/pct_scale.sv ----
`timescale 1ns/1ps
module pct_scale #(
	parameter int W = 34
) (
	// Operands
	input  wire logic signed [W-1:0]                        base_i,
	input  wire logic signed [ref_combiner_pkg::PCT_W-1:0] pct_i,
	// Result
	output logic signed [W-1:0]                             part_o
);
	localparam int PW = W + ref_combiner_pkg::PCT_W;
	localparam logic signed [PW-1:0] FULL = PW'(ref_combiner_pkg::PCT_FULL);

	logic signed [PW-1:0] prod;

	// The percentage is held in hundredths, so full scale is one hundred percent.
	assign prod   = PW'(base_i) * PW'(pct_i);
	assign part_o = W'(prod / FULL);
endmodule

// ---- verilog/ref_combiner_pkg.sv ----
package ref_combiner_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int                ADDR_W      = 8;
	localparam logic [ADDR_W-1:0] OFS_QSTOP   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_JOG     = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MODE    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PRESET0 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CATCH   = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_OUTPUT_CURRENT_CEILING    = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_LOW_CURRENT_THRESHOLD    = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_FLOOR   = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_CEIL    = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_RESULT  = 8'h38;
	localparam int                PRESET_NUM  = 4;

	// ************************************************************
	// Ranges and reset values
	// ************************************************************
	localparam int QSTOP_W      = 19;
	localparam int QSTOP_MIN_CS = 2;
	localparam int QSTOP_MAX_CS = 360000;
	localparam int QSTOP_RST_CS = 300;
	localparam int JOG_RST_MHZ  = 10000;
	localparam int FLOOR_RST    = 0;
	localparam int CEIL_RST     = 50000;
	localparam int PCT_W        = 16;
	localparam int PCT_FULL     = 10000;
	localparam int PRESET_RST   = 0;
	localparam int CATCH_RST    = 0;
	localparam int OUTPUT_CURRENT_CEILING_RST     = 1600;
	localparam int LOW_CURRENT_THRESHOLD_RST     = 0;

	// ************************************************************
	// Preset combining modes
	// ************************************************************
	localparam logic [1:0] MODE_ADD    = 2'h0;
	localparam logic [1:0] MODE_REL    = 2'h1;
	localparam logic [1:0] MODE_SWITCH = 2'h2;

	// ************************************************************
	// Control and status bits
	// ************************************************************
	localparam int        CTRL_W          = 4;
	localparam int        CTRL_PANEL_JOG  = 0;
	localparam int        CTRL_ROUTE_DOUT = 1;
	localparam int        CTRL_ROUTE_RLY  = 2;
	localparam int        CTRL_PRESET_SER = 3;
	localparam logic [3:0] CTRL_RST       = 4'h0;
	localparam int        ST_LOW_WARN     = 0;
	localparam int        ST_OUTPUT_CURRENT_CEILING         = 1;
	localparam int        ST_JOG          = 2;
	localparam int        ST_QSTOP        = 3;
	localparam int        ST_WARN_EN      = 4;

endpackage

// ---- verilog/warn_gate.sv ----
`timescale 1ns/1ps
module warn_gate (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// Run state
	gate_if.gate      g
);
	typedef enum logic [1:0] {GS_STOPPED, GS_RAMPING, GS_SETTLED} gate_state_t;

	gate_state_t state_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= GS_STOPPED;
		end else if (ce_i) begin
			case (state_q)
				GS_STOPPED: begin
					if (g.start && !g.stop) begin
						state_q <= GS_RAMPING;
					end
				end
				GS_RAMPING: begin
					if (g.stop) begin
						state_q <= GS_STOPPED;
					end else if (g.at_ref) begin
						state_q <= GS_SETTLED;
					end
				end
				default: begin
					if (g.stop) begin
						state_q <= GS_STOPPED;
					end
				end
			endcase
		end
	end

	assign g.enable = (state_q == GS_SETTLED);

	stop_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && g.stop) |=> !g.enable)
		else $error("warnings still enabled after stop");
endmodule
